// file: bench/mfm_fault_manager_checker.sv
// Purpose: Port-level checks for the motor fault manager.
// Assumes: Bound to every mfm_fault_manager instance.
// Notes:   Report latencies of one or two cycles are assumed.
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_manager_checker
	import mfm_pkg::*;
#(
	parameter logic [CNT_W-1:0] STALL_RETRY_CYCLES = 32'h0000_0010,
	parameter logic [CNT_W-1:0] OC_RETRY_CYCLES    = 32'h0000_0010
) (
	// Clock and reset
	input wire logic             i_clk,
	input wire logic             i_rst_b,
	// Watched inputs
	input wire logic             i_bus_limit_en,
	input wire logic             i_active_brake_en,
	input wire logic [CUR_W-1:0] i_bus_current,
	input wire logic [CUR_W-1:0] i_bus_current_limit,
	input wire logic             i_supply_lockout,
	input wire logic             i_analog_rail_uv,
	input wire logic             i_regulator_overcurrent,
	input wire logic             i_pump_undervolt,
	input wire logic             i_overvoltage_guard_en,
	input wire logic             i_phase_overcurrent,
	input wire logic [1:0]       i_phase_overcurrent_action,
	input wire logic [3:0]       i_stall_action,
	input wire logic             i_alarm_pin_en,
	input wire logic             i_fault_clear_cmd,
	// Watched outputs
	input wire logic             o_fault_out_n_o,
	input wire logic             o_fault_out_n_oe,
	input wire logic             o_alarm,
	input wire logic             o_limit_active,
	input wire mfm_stage_t       o_stage,
	input wire logic             o_digital_en,
	input wire logic [2:0]       o_stage_fault_flags,
	input wire logic [1:0]       o_control_fault_flags
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_b);

////////////////////////////////////////////////////////////////
// Release level of the limiter, 95 percent of the limit
logic [22:0] floor_w;
assign floor_w = ({7'h00, i_bus_current_limit} * {16'h0000, HYST_KEEP}) / {16'h0000, PCT_FULL};

sequence s_lockout;
	i_supply_lockout || i_analog_rail_uv || i_regulator_overcurrent;
endsequence
sequence s_no_clear;
	!i_fault_clear_cmd [*3];
endsequence

property p_lockout;
	s_lockout |=> o_stage == MFM_STAGE_HIZ && !o_digital_en;
endproperty
property p_oc_latch;
	i_phase_overcurrent && i_phase_overcurrent_action != OC_ACT_RETRY |=> o_stage == MFM_STAGE_HIZ;
endproperty
property p_pump;
	i_pump_undervolt |=> o_stage != MFM_STAGE_ACTIVE && o_stage_fault_flags[0];
endproperty
property p_ov_off;
	!i_overvoltage_guard_en |=> !o_stage_fault_flags[1];
endproperty
property p_od;
	o_fault_out_n_o == 1'b0;
endproperty
property p_pins;
	o_fault_out_n_oe |-> o_alarm == $past(i_alarm_pin_en);
endproperty
property p_brake;
	i_active_brake_en |=> !o_limit_active;
endproperty
property p_enter;
	i_bus_limit_en && !i_active_brake_en && i_bus_current > i_bus_current_limit |=> o_limit_active;
endproperty
property p_hyst;
	o_limit_active && i_bus_limit_en && !i_active_brake_en && {7'h00, i_bus_current} >= floor_w
		|=> o_limit_active;
endproperty
property p_flag_hold;
	s_no_clear ##0 (o_control_fault_flags[0] && i_stall_action[3:2] == 2'h0) |=> o_control_fault_flags[0];
endproperty

a_lockout: assert property (p_lockout) else $error("lockout left stage driven");
a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not Hi-Z");
a_pump: assert property (p_pump) else $error("pump fault not acted on");
a_ov_off: assert property (p_ov_off) else $error("unguarded overvoltage flagged");
a_od: assert property (p_od) else $error("fault pin driven high");
a_pins: assert property (p_pins) else $error("alarm disagrees with enable");
a_brake: assert property (p_brake) else $error("limiter on while braking");
a_enter: assert property (p_enter) else $error("limiter did not engage");
a_hyst: assert property (p_hyst) else $error("limiter released inside band");
a_flag_hold: assert property (p_flag_hold) else $error("latched flag dropped");
endmodule

bind mfm_fault_manager mfm_fault_manager_checker #(
	.STALL_RETRY_CYCLES(STALL_RETRY_CYCLES),
	.OC_RETRY_CYCLES   (OC_RETRY_CYCLES)
) mfm_fault_manager_checker_inst (.*);
`default_nettype wire

// file: bench/mfm_host_model.sv
// Purpose: Host and board around the fault manager.
// Assumes: Fault pin has a pull-up on the board.
// Notes:   Clear write lands one cycle after the request, like a bus write.
`timescale 1ns/1ps
`default_nettype none
module mfm_host_model (
	// Clock
	input  wire logic i_clk,
	// Fault pin driver
	input  wire logic i_oe,
	input  wire logic i_o,
	// Host request
	input  wire logic i_clear_req,
	// To the block
	output wire logic o_pin,
	output var  logic o_fault_clear_cmd = 1'b0
);
// Released pin floats up through the pull-up
assign o_pin = i_oe ? i_o : 1'b1;
always @(posedge i_clk) begin
	o_fault_clear_cmd <= i_clear_req;
end
endmodule
`default_nettype wire

// file: bench/test_motor_fault_manager.sv
// Purpose: Self-checking bench for the motor fault manager.
// Assumes: Short retry counts stand in for the long real ones.
// Notes:   Pin level seen through the host model's pull-up.
`timescale 1ns/1ps
`default_nettype none
module test_motor_fault_manager import mfm_pkg::*;;
localparam logic [CNT_W-1:0] SR = 32'h0000_0014;
localparam logic [CNT_W-1:0] OCR = 32'h0000_000A;
logic i_clk = 1'b0, i_rst_b = 1'b0, clear_req = 1'b0;
logic i_bus_limit_en, i_active_brake_en, i_supply_lockout, i_analog_rail_uv, i_pump_undervolt;
logic i_overvolt, i_phase_overcurrent, i_regulator_overcurrent, i_stall_fault;
logic i_overvoltage_guard_en, i_alarm_pin_en, i_fault_clear_cmd, i_fault_out_n;
logic [15:0] i_bus_current, i_bus_current_limit, i_speed_target, i_current_target;
logic [15:0] i_sense_level, i_hw_stall_current_level, o_capped_speed_target, o_capped_current_target;
logic [1:0] i_phase_overcurrent_action, o_control_fault_flags;
logic [3:0] i_stall_action, i_hw_stall_current_action;
logic o_fault_out_n_o, o_fault_out_n_oe, o_fault_pin_level, o_alarm, o_limit_active, o_digital_en;
logic [2:0] o_stage_fault_flags;
mfm_stage_t o_stage;
int num_errors = 0, cmp_count = 0, lim, tgt, flo;

mfm_fault_manager #(.STALL_RETRY_CYCLES(SR), .OC_RETRY_CYCLES(OCR)) mfm_fault_manager_inst (
	.i_clk, .i_rst_b, .i_bus_limit_en, .i_active_brake_en, .i_bus_current, .i_bus_current_limit,
	.i_speed_target, .i_current_target, .i_supply_lockout, .i_analog_rail_uv, .i_pump_undervolt,
	.i_overvolt, .i_phase_overcurrent, .i_regulator_overcurrent, .i_stall_fault, .i_sense_level,
	.i_hw_stall_current_level, .i_overvoltage_guard_en, .i_phase_overcurrent_action,
	.i_stall_action, .i_hw_stall_current_action, .i_alarm_pin_en, .i_fault_clear_cmd,
	.i_fault_out_n, .o_fault_out_n_o, .o_fault_out_n_oe, .o_fault_pin_level, .o_alarm,
	.o_capped_speed_target, .o_capped_current_target, .o_limit_active, .o_stage, .o_digital_en,
	.o_stage_fault_flags, .o_control_fault_flags);
mfm_host_model mfm_host_model_inst (.i_clk, .i_oe(o_fault_out_n_oe), .i_o(o_fault_out_n_o),
	.i_clear_req(clear_req), .o_pin(i_fault_out_n), .o_fault_clear_cmd(i_fault_clear_cmd));

always #12.5 i_clk = ~i_clk;

////////////////////////////////////////////////////////////////
task automatic wt(input int n);
	repeat (n) @(posedge i_clk);
	#1;
endtask
task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	cmp_count++;
	if (g !== e) begin
		num_errors++;
		$display("FAIL %s expected %h seen %h", nm, e, g);
	end
endtask
task automatic end_of_test;
	$display("compares %0d mismatches %0d", cmp_count, num_errors);
	if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
endtask
task automatic clr;
	@(posedge i_clk) clear_req <= 1'b1;
	@(posedge i_clk) clear_req <= 1'b0;
endtask
function automatic mfm_resp_t resp_of(input logic [3:0] c);
	if (c[3]) return (c == 4'h8) ? MFM_RESP_REPORT : MFM_RESP_NONE;
	return c[2] ? MFM_RESP_RETRY : MFM_RESP_LATCH;
endfunction
function automatic mfm_stage_t stage_of(input logic [3:0] c);
	if (c[3]) return MFM_STAGE_ACTIVE;
	case (c[1:0])
		2'h2: return MFM_STAGE_HS_BRAKE;
		2'h3: return MFM_STAGE_LS_BRAKE;
		default: return MFM_STAGE_HIZ;
	endcase
endfunction
task automatic stall_case(input logic hw, input logic [3:0] c);
	mfm_resp_t r;
	logic en, act, rep;
	r = resp_of(c);
	en = 1'($urandom_range(1, 0));
	act = (r == MFM_RESP_LATCH || r == MFM_RESP_RETRY);
	rep = (r == MFM_RESP_REPORT);
	@(posedge i_clk);
	i_alarm_pin_en <= en;
	if (hw) {i_hw_stall_current_action, i_sense_level} <= {c, 16'h0200};
	else {i_stall_action, i_stall_fault} <= {c, 1'b1};
	wt(4);
	chk("stage", stage_of(c), o_stage);
	chk("ctrl flag", r != MFM_RESP_NONE, o_control_fault_flags[hw]);
	chk("pin", !(act | (rep & !en)), o_fault_pin_level);
	chk("alarm", en & (act | rep), o_alarm);
	@(posedge i_clk) {i_sense_level, i_stall_fault} <= {16'h0010, 1'b0};
	if (r == MFM_RESP_LATCH) begin
		wt(8);
		chk("held stage", stage_of(c), o_stage);
		chk("held flag", 1'b1, o_control_fault_flags[hw]);
		clr();
		wt(4);
		chk("cleared", MFM_STAGE_ACTIVE, o_stage);
	end else if (r == MFM_RESP_RETRY) begin
		wt(SR - 4);
		chk("waiting", stage_of(c), o_stage);
		wt(10);
		chk("retried", MFM_STAGE_ACTIVE, o_stage);
	end
	$display("stall case %0d code %h done", hw, c);
endtask
task automatic level_case(input int k);
	@(posedge i_clk);
	{i_supply_lockout, i_analog_rail_uv, i_regulator_overcurrent, i_pump_undervolt, i_overvolt}
		<= 5'h10 >> k;
	wt(4);
	chk("stage", MFM_STAGE_HIZ, o_stage);
	chk("digital", k > 2, o_digital_en);
	chk("gate flags", k == 3 ? 3'h1 : k == 4 ? 3'h2 : 3'h0, o_stage_fault_flags);
	chk("pin", k < 3, o_fault_pin_level);
	@(posedge i_clk);
	{i_supply_lockout, i_analog_rail_uv, i_regulator_overcurrent, i_pump_undervolt, i_overvolt}
		<= 5'h00;
	wt(4);
	chk("recovered", {1'b1, MFM_STAGE_ACTIVE}, {o_digital_en, o_stage});
	$display("level case %0d done", k);
endtask

initial begin
	repeat (60000) @(posedge i_clk);
	num_errors++;
	$display("FAIL watchdog expected done seen hang");
	end_of_test();
end

initial begin
	{i_bus_limit_en, i_active_brake_en, i_supply_lockout, i_analog_rail_uv, i_pump_undervolt} = '0;
	{i_overvolt, i_phase_overcurrent, i_regulator_overcurrent, i_stall_fault, i_alarm_pin_en} = '0;
	{i_bus_current, i_bus_current_limit, i_speed_target, i_current_target} = '0;
	{i_sense_level, i_hw_stall_current_level} = {16'h0010, 16'h0100};
	{i_stall_action, i_hw_stall_current_action, i_phase_overcurrent_action} = 10'h3FF;
	i_overvoltage_guard_en = 1'b1;
	void'($urandom(92));
	wt(12);
	chk("reset pins", 16'h0011, {o_fault_pin_level, o_alarm, o_fault_out_n_oe, o_stage});
	chk("reset misc", 16'h0000, {o_digital_en, o_limit_active, o_stage_fault_flags,
		o_control_fault_flags, o_capped_speed_target[0], o_capped_current_target[0]});
	i_rst_b <= 1'b1;
	wt(3);
	chk("after reset", {1'b1, MFM_STAGE_ACTIVE}, {o_digital_en, o_stage});
	for (int k = 0; k < 5; k++) level_case(k);
	@(posedge i_clk) {i_overvoltage_guard_en, i_overvolt} <= 2'h1;
	wt(4);
	chk("ov unguarded", 16'h0020, {o_fault_pin_level, o_stage_fault_flags, o_stage});
	@(posedge i_clk) {i_overvoltage_guard_en, i_overvolt} <= 2'h2;
	for (int h = 0; h < 2; h++) for (int c = 0; c < 16; c++) stall_case(h[0], c[3:0]);
	for (int a = 0; a < 4; a++) begin
		@(posedge i_clk) {i_phase_overcurrent_action, i_phase_overcurrent} <= {a[1:0], 1'b1};
		wt(4);
		chk("oc", 16'h0009, {o_stage_fault_flags[2], o_fault_pin_level, o_stage});
		@(posedge i_clk) i_phase_overcurrent <= 1'b0;
		wt(OCR + 6);
		chk("oc after", a == 1 ? MFM_STAGE_ACTIVE : MFM_STAGE_HIZ, o_stage);
		clr();
		wt(4);
		chk("oc cleared", MFM_STAGE_ACTIVE, o_stage);
	end
	for (int a = 1; a >= 0; a--) begin
		@(posedge i_clk);
		{i_phase_overcurrent_action, i_stall_action} <= {a[1:0], 4'h4};
		{i_phase_overcurrent, i_stall_fault} <= 2'h3;
		wt(4);
		@(posedge i_clk) {i_phase_overcurrent, i_stall_fault} <= 2'h0;
		wt(OCR + 6);
		chk("slow retry wins", MFM_STAGE_HIZ, o_stage);
		wt(SR);
		chk("after slow", a == 1 ? MFM_STAGE_ACTIVE : MFM_STAGE_HIZ, o_stage);
		clr();
		wt(4);
		chk("priority end", MFM_STAGE_ACTIVE, o_stage);
	end
	$display("priority cases done");
	for (int i = 0; i < 20; i++) begin
		lim = $urandom_range(4000, 200);
		tgt = $urandom_range(60000, 1000);
		flo = lim * HYST_KEEP / PCT_FULL;
		@(posedge i_clk);
		{i_bus_limit_en, i_active_brake_en, i_bus_current_limit} <= {2'h2, lim[15:0]};
		{i_bus_current, i_speed_target, i_current_target} <= {lim[16:1], tgt[15:0], ~tgt[15:0]};
		wt(4);
		chk("caps", {1'b0, tgt[14:0]}, {o_limit_active, o_capped_speed_target[14:0]});
		chk("cap cur", ~tgt[15:0], o_capped_current_target);
		@(posedge i_clk) i_bus_current <= 16'(lim + 1);
		wt(2);
		chk("limiting", 1'b1, o_limit_active);
		wt(4);
		chk("capped", 1'b1, 1'(o_capped_speed_target < tgt[15:0]));
		@(posedge i_clk) i_bus_current <= flo[15:0];
		wt(3);
		chk("band hold", 1'b1, o_limit_active);
		@(posedge i_clk) i_bus_current <= 16'(flo - 1);
		wt(2);
		chk("band exit", 1'b0, o_limit_active);
		@(posedge i_clk) {i_bus_current, i_active_brake_en} <= {16'(lim + 1), 1'b1};
		wt(3);
		chk("braking", 1'b0, o_limit_active);
		@(posedge i_clk) {i_active_brake_en, i_bus_limit_en} <= 2'h0;
		wt(3);
		chk("disabled", 1'b0, o_limit_active);
	end
	$display("limiter cases done");
	end_of_test();
end
endmodule
`default_nettype wire

// file: src/mfm_fault_manager.sv
// Purpose: Supply current limiter and fault response for a three-phase driver.
// Assumes: All inputs synchronous to i_clk; comparators and stall detectors outside.
// Notes:   Status and pins follow with the stage, one cycle after it for latched faults, well inside the allowed latency.
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_manager
	import mfm_pkg::*;
#(
	parameter logic [CNT_W-1:0] STALL_RETRY_CYCLES = STALL_RETRY_CYC[CNT_W-1:0],
	parameter logic [CNT_W-1:0] OC_RETRY_CYCLES    = OC_RETRY_CYC[CNT_W-1:0]
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// Supply current limiter
	input  wire logic             i_bus_limit_en,
	input  wire logic             i_active_brake_en,
	input  wire logic [CUR_W-1:0] i_bus_current,
	input  wire logic [CUR_W-1:0] i_bus_current_limit,
	input  wire logic [TGT_W-1:0] i_speed_target,
	input  wire logic [TGT_W-1:0] i_current_target,
	// Fault detectors
	input  wire logic             i_supply_lockout,
	input  wire logic             i_analog_rail_uv,
	input  wire logic             i_pump_undervolt,
	input  wire logic             i_overvolt,
	input  wire logic             i_phase_overcurrent,
	input  wire logic             i_regulator_overcurrent,
	input  wire logic             i_stall_fault,
	input  wire logic [CUR_W-1:0] i_sense_level,
	input  wire logic [CUR_W-1:0] i_hw_stall_current_level,
	// Configuration
	input  wire logic             i_overvoltage_guard_en,
	input  wire logic [1:0]       i_phase_overcurrent_action,
	input  wire logic [3:0]       i_stall_action,
	input  wire logic [3:0]       i_hw_stall_current_action,
	input  wire logic             i_alarm_pin_en,
	input  wire logic             i_fault_clear_cmd,
	// Open-drain fault pin
	input  wire logic             i_fault_out_n,
	output var  logic             o_fault_out_n_o,
	output var  logic             o_fault_out_n_oe,
	output var  logic             o_fault_pin_level,
	// Alarm pin
	output var  logic             o_alarm,
	// Limiter results
	output var  logic [TGT_W-1:0] o_capped_speed_target,
	output var  logic [TGT_W-1:0] o_capped_current_target,
	output var  logic             o_limit_active,
	// Power stage
	output var  mfm_stage_t       o_stage,
	output var  logic             o_digital_en,
	// Status: {phase overcurrent, overvoltage, pump undervolt}
	output var  logic [2:0]       o_stage_fault_flags,
	// Status: {hw stall current fault, stall fault}
	output var  logic [1:0]       o_control_fault_flags
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic             limiting;
		logic [TGT_W-1:0] cap_speed;
		logic [TGT_W-1:0] cap_cur;
		logic             oc_latched;
		logic             stall_latched;
		mfm_stage_t       stall_lstage;
		logic             hw_latched;
		mfm_stage_t       hw_lstage;
		mfm_stage_t       stage;
		logic             dig_en;
		logic             fault_oe;
		logic             alarm;
		logic [2:0]       stage_flags;
		logic [1:0]       ctrl_flags;
		logic             pin_level;
		logic             od_drive;
	} mfm_state_t;

	mfm_state_t q, n;

	// Longer retry interval takes precedence over the shorter one
	localparam logic STALL_IS_SLOW = (STALL_RETRY_CYCLES >= OC_RETRY_CYCLES);

	////////////////////////////////////////////////////////////////////////////
	// Stall decoders and retry timers

	mfm_resp_t  stall_resp;
	mfm_stage_t stall_stage;
	mfm_resp_t  hw_resp;
	mfm_stage_t hw_stage;
	logic       hw_fault;
	logic       oc_busy;
	logic       stall_busy;
	logic       hw_busy;
	logic       oc_retry_ev;
	logic       stall_retry_ev;
	logic       hw_retry_ev;

	assign hw_fault       = (i_sense_level > i_hw_stall_current_level);
	assign oc_retry_ev    = i_phase_overcurrent
		& (i_phase_overcurrent_action == OC_ACT_RETRY);
	assign stall_retry_ev = i_stall_fault & (stall_resp == MFM_RESP_RETRY);
	assign hw_retry_ev    = hw_fault & (hw_resp == MFM_RESP_RETRY);

	mfm_stall_decode u_stall_dec (
		.i_action (i_stall_action),
		.o_resp   (stall_resp),
		.o_stage  (stall_stage)
	);

	mfm_stall_decode u_hw_dec (
		.i_action (i_hw_stall_current_action),
		.o_resp   (hw_resp),
		.o_stage  (hw_stage)
	);

	mfm_retry_timer #(
		.RETRY_CYC (OC_RETRY_CYCLES)
	) u_oc_tmr (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_fault (oc_retry_ev),
		.o_busy  (oc_busy)
	);

	mfm_retry_timer #(
		.RETRY_CYC (STALL_RETRY_CYCLES)
	) u_stall_tmr (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_fault (stall_retry_ev),
		.o_busy  (stall_busy)
	);

	mfm_retry_timer #(
		.RETRY_CYC (STALL_RETRY_CYCLES)
	) u_hw_tmr (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_fault (hw_retry_ev),
		.o_busy  (hw_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Limiter helpers

	// Ramps one step per cycle while limiting, never overshooting the commanded value; follows it directly otherwise
	function automatic logic [TGT_W-1:0] cap_step(
		input logic [TGT_W-1:0] cap,
		input logic [TGT_W-1:0] cmd,
		input logic             hold,
		input logic             over
	);
		logic [TGT_W-1:0] r;
		r = cap;
		if (!hold) begin
			r = cmd;
		end else if (over) begin
			if (cap > CAP_STEP) begin
				r = cap - CAP_STEP;
			end else begin
				r = '0;
			end
		end else if (cap > cmd) begin
			r = cmd;
		end else if (cap < cmd) begin
			r = cap + CAP_STEP;
		end
		return r;
	endfunction

	logic [CUR_W+6:0] keep_prod;
	logic [CUR_W+6:0] keep_quot;
	logic [CUR_W-1:0] lo_thresh;
	logic             over_limit;
	logic             lim_allowed;

	always_comb begin
		keep_prod = {7'h00, i_bus_current_limit} * {16'h0000, HYST_KEEP};
		keep_quot = keep_prod / {16'h0000, PCT_FULL};
		lo_thresh = keep_quot[CUR_W-1:0];
	end

	assign over_limit  = (i_bus_current > i_bus_current_limit);
	assign lim_allowed = i_bus_limit_en & ~i_active_brake_en;

	////////////////////////////////////////////////////////////////////////////
	// Fault classification

	logic lockout;
	logic ov_act;
	logic oc_latch_ev;
	logic stall_latch_ev;
	logic hw_latch_ev;
	logic stall_report;
	logic hw_report;
	logic actionable;
	logic report_only;
	logic clr;

	always_comb begin
		// Supply, rail and regulator faults: silent, digital held off
		lockout = i_supply_lockout | i_analog_rail_uv | i_regulator_overcurrent;
		ov_act  = i_overvolt & i_overvoltage_guard_en;
		oc_latch_ev    = i_phase_overcurrent
			& (i_phase_overcurrent_action != OC_ACT_RETRY);
		stall_latch_ev = i_stall_fault & (stall_resp == MFM_RESP_LATCH);
		hw_latch_ev    = hw_fault & (hw_resp == MFM_RESP_LATCH);
		stall_report   = i_stall_fault & (stall_resp == MFM_RESP_REPORT);
		hw_report      = hw_fault & (hw_resp == MFM_RESP_REPORT);
		clr = i_fault_clear_cmd;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = q;

		// Limiter with hysteresis
		if (!lim_allowed) begin
			n.limiting = 1'b0;
		end else if (over_limit) begin
			n.limiting = 1'b1;
		end else if (i_bus_current < lo_thresh) begin
			n.limiting = 1'b0;
		end
		n.cap_speed = cap_step(q.cap_speed, i_speed_target, n.limiting, over_limit);
		n.cap_cur   = cap_step(q.cap_cur, i_current_target, n.limiting, over_limit);

		// Latches: a new event wins over a clear in the same cycle
		n.oc_latched    = oc_latch_ev | (q.oc_latched & ~clr);
		n.stall_latched = stall_latch_ev | (q.stall_latched & ~clr);
		n.hw_latched    = hw_latch_ev | (q.hw_latched & ~clr);
		if (stall_latch_ev && !(q.stall_latched && !clr)) begin
			n.stall_lstage = stall_stage;
		end
		if (hw_latch_ev && !(q.hw_latched && !clr)) begin
			n.hw_lstage = hw_stage;
		end

		// Power stage by priority
		if (lockout) begin
			n.stage = MFM_STAGE_HIZ;
		end else if (n.oc_latched) begin
			n.stage = MFM_STAGE_HIZ;
		end else if (n.stall_latched) begin
			n.stage = n.stall_lstage;
		end else if (n.hw_latched) begin
			n.stage = n.hw_lstage;
		end else if (i_pump_undervolt || ov_act) begin
			n.stage = MFM_STAGE_HIZ;
		end else if (STALL_IS_SLOW && stall_busy) begin
			n.stage = stall_stage;
		end else if (STALL_IS_SLOW && hw_busy) begin
			n.stage = hw_stage;
		end else if (oc_busy) begin
			n.stage = MFM_STAGE_HIZ;
		end else if (stall_busy) begin
			n.stage = stall_stage;
		end else if (hw_busy) begin
			n.stage = hw_stage;
		end else begin
			n.stage = MFM_STAGE_ACTIVE;
		end
		n.dig_en = ~lockout;

		// Reporting, with the stage decision, one cycle later for latched faults
		n.stage_flags = {q.oc_latched | oc_busy, ov_act, i_pump_undervolt};
		n.ctrl_flags  = {q.hw_latched | hw_busy | hw_report,
			q.stall_latched | stall_busy | stall_report};
		n.fault_oe  = actionable | (report_only & ~i_alarm_pin_en);
		n.alarm     = i_alarm_pin_en & (actionable | report_only);
		n.pin_level = i_fault_out_n;
		n.od_drive  = 1'b0;

		if (!i_rst_b) begin
			n              = '0;
			n.cap_speed    = CAP_RST;
			n.cap_cur      = CAP_RST;
			n.stall_lstage = MFM_STAGE_HIZ;
			n.hw_lstage    = MFM_STAGE_HIZ;
			n.stage        = MFM_STAGE_HIZ;
			n.pin_level    = 1'b1;
		end
	end

	always_comb begin
		actionable = q.oc_latched | oc_busy | i_pump_undervolt | ov_act
			| q.stall_latched | stall_busy | q.hw_latched | hw_busy;
		report_only = stall_report | hw_report;
	end

	always_ff @(posedge i_clk) begin
		q <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Open-drain: only ever drives low, pull-up supplies the high level
	assign o_fault_out_n_o         = q.od_drive;
	assign o_fault_out_n_oe        = q.fault_oe;
	assign o_fault_pin_level       = q.pin_level;
	assign o_alarm                 = q.alarm;
	assign o_capped_speed_target   = q.cap_speed;
	assign o_capped_current_target = q.cap_cur;
	assign o_limit_active          = q.limiting;
	assign o_stage                 = q.stage;
	assign o_digital_en            = q.dig_en;
	assign o_stage_fault_flags     = q.stage_flags;
	assign o_control_fault_flags   = q.ctrl_flags;

endmodule
`default_nettype wire

// file: src/mfm_pkg.sv
// Purpose: Shared constants and types for the motor fault manager.
// Assumes: 40 MHz core clock, synchronous active-low reset.
// Notes:   Retry times default to 1000 ms (stall) and 500 ms (overcurrent) here; the top exposes them as parameters.
//
// What this block does
// - Cap targets to hold supply current limit
// - Report when supply current limit restricts target
// - Active braking disables supply current limiting
// - Five percent hysteresis on limit threshold
// - Actionable faults pull fault pin low
// - Alarm enabled: actionable faults raise alarm
// - Report-only faults: pin or alarm by enable
// - Priority latched, slow retry, fast retry, report
// - Latched fault holds until host clears it
// - Retry faults resume after retry interval
// - Pins and status follow within 200 ms
// - Latched fault clears within 200 ms
// - Supply or rail undervoltage: Hi-Z, digital off
// - Pump undervoltage: Hi-Z, report, auto recover
// - Overvoltage acts only when guard enabled
// - Phase overcurrent latches or retries per action
// - Regulator overcurrent: Hi-Z, digital off, silent
// - Stall latched modes: Hi-Z or brakes
// - Stall retry modes: Hi-Z or brakes
// - Stall 1000 reports only; 1xx1 ignored
// - Hardware stall current latched modes
// - Hardware stall current retry, report, ignore
package mfm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam longint unsigned CLK_HZ         = 40_000_000;
	localparam longint unsigned MS_PER_S       = 1000;
	localparam longint unsigned STALL_RETRY_MS = 1000;
	localparam longint unsigned OC_RETRY_MS    = 500;
	localparam longint unsigned REPORT_MAX_MS  = 200;
	localparam longint unsigned CLEAR_MAX_MS   = 200;
	localparam longint unsigned STALL_RETRY_CYC = STALL_RETRY_MS * CLK_HZ / MS_PER_S;
	localparam longint unsigned OC_RETRY_CYC    = OC_RETRY_MS * CLK_HZ / MS_PER_S;
	localparam longint unsigned REPORT_MAX_CYC  = REPORT_MAX_MS * CLK_HZ / MS_PER_S;
	localparam longint unsigned CLEAR_MAX_CYC   = CLEAR_MAX_MS * CLK_HZ / MS_PER_S;
	localparam int unsigned     CNT_W           = 32;

	////////////////////////////////////////////////////////////////////////////
	// Widths and limiter constants
	localparam int unsigned TGT_W = 16;
	localparam int unsigned CUR_W = 16;
	localparam logic [6:0]  PCT_FULL     = 7'h64;
	localparam logic [6:0]  HYST_PCT     = 7'h05;
	localparam logic [6:0]  HYST_KEEP    = PCT_FULL - HYST_PCT;
	localparam logic [TGT_W-1:0] CAP_STEP = 16'h0001;
	localparam logic [TGT_W-1:0] CAP_RST  = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Action codes
	localparam logic [1:0] OC_ACT_LATCH = 2'h0;
	localparam logic [1:0] OC_ACT_RETRY = 2'h1;

	typedef enum logic [1:0] {
		MFM_STAGE_ACTIVE,
		MFM_STAGE_HIZ,
		MFM_STAGE_HS_BRAKE,
		MFM_STAGE_LS_BRAKE
	} mfm_stage_t;

	typedef enum logic [1:0] {
		MFM_RESP_NONE,
		MFM_RESP_REPORT,
		MFM_RESP_LATCH,
		MFM_RESP_RETRY
	} mfm_resp_t;

endpackage

// file: src/mfm_retry_timer.sv
// Purpose: Hold a retry fault busy until its interval lapses after it clears.
// Assumes: i_fault is a level, high while the retry fault is present.
// Notes:   Interval restarts whenever the fault reappears.
`timescale 1ns/1ps
`default_nettype none
module mfm_retry_timer
	import mfm_pkg::*;
#(
	parameter logic [CNT_W-1:0] RETRY_CYC = 32'h0000_0010
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Fault level
	input  wire logic i_fault,
	// Busy while present or waiting
	output var  logic o_busy
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
	} mfm_tmr_t;

	mfm_tmr_t q, n;

	always_comb begin
		n = q;
		if (i_fault) begin
			n.cnt  = RETRY_CYC;
			n.busy = 1'b1;
		end else if (q.busy) begin
			if (q.cnt <= 32'h0000_0001) begin
				n.cnt  = '0;
				n.busy = 1'b0;
			end else begin
				n.cnt = q.cnt - 32'h0000_0001;
			end
		end
		if (!i_rst_b) begin
			n = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		q <= n;
	end

	assign o_busy = q.busy;

endmodule
`default_nettype wire

// file: src/mfm_stall_decode.sv
// Purpose: Decode a four-bit stall action setting into response and stage.
// Assumes: Setting is static or changes rarely.
// Notes:   Codes 1010, 1100 and 1110 are treated as no action.
`timescale 1ns/1ps
`default_nettype none
module mfm_stall_decode
	import mfm_pkg::*;
(
	// Setting
	input  wire logic [3:0] i_action,
	// Decoded
	output var mfm_resp_t   o_resp,
	output var mfm_stage_t  o_stage
);

	always_comb begin
		o_resp  = MFM_RESP_NONE;
		o_stage = MFM_STAGE_ACTIVE;
		casez (i_action)
			4'b1??1: begin
				o_resp = MFM_RESP_NONE;
			end
			4'b1000: begin
				o_resp = MFM_RESP_REPORT;
			end
			4'b000?: begin
				o_resp  = MFM_RESP_LATCH;
				o_stage = MFM_STAGE_HIZ;
			end
			4'b0010: begin
				o_resp  = MFM_RESP_LATCH;
				o_stage = MFM_STAGE_HS_BRAKE;
			end
			4'b0011: begin
				o_resp  = MFM_RESP_LATCH;
				o_stage = MFM_STAGE_LS_BRAKE;
			end
			4'b010?: begin
				o_resp  = MFM_RESP_RETRY;
				o_stage = MFM_STAGE_HIZ;
			end
			4'b0110: begin
				o_resp  = MFM_RESP_RETRY;
				o_stage = MFM_STAGE_HS_BRAKE;
			end
			4'b0111: begin
				o_resp  = MFM_RESP_RETRY;
				o_stage = MFM_STAGE_LS_BRAKE;
			end
			default: begin
				o_resp  = MFM_RESP_NONE;
				o_stage = MFM_STAGE_ACTIVE;
			end
		endcase
	end

endmodule
`default_nettype wire
